// >>> hw/dsa_pkg.sv
// shared constants for the short-address dma channel (idle and repeat modes)
// assumes a 32-bit apb slave port and a 24-bit internal bus with a 16-bit data path
package dsa_pkg;

  // apb register byte offsets
  localparam logic [7:0] DSA_OFF_CTRL   = 8'h00; // channel control
  localparam logic [7:0] DSA_OFF_MEM    = 8'h04; // memory_side_address
  localparam logic [7:0] DSA_OFF_PER    = 8'h08; // peripheral_low_address
  localparam logic [7:0] DSA_OFF_COUNT  = 8'h0c; // transfer_count (live/initial bytes)
  localparam logic [7:0] DSA_OFF_STATUS = 8'h10; // done flag, busy

  // control register fields
  localparam int DSA_BIT_EN     = 0; // channel_enable_bit
  localparam int DSA_BIT_REPEAT = 1; // 0 idle mode, 1 repeat mode
  localparam int DSA_BIT_SIZE   = 2; // unit_size_select: 0 byte, 1 word
  localparam int DSA_BIT_DIR    = 3; // step_direction_select: 0 up, 1 down
  localparam int DSA_SRC_LO     = 4; // activation source select, low bit
  localparam int DSA_SRC_HI     = 6; // activation source select, high bit

  // status register fields
  localparam int DSA_BIT_DONE = 0; // idle-mode end flag, write one to clear
  localparam int DSA_BIT_BUSY = 1; // a transfer is in flight

  // widths
  localparam int DSA_AW   = 24; // memory address width
  localparam int DSA_DW   = 16; // internal data width
  localparam int DSA_CW   = 16; // idle-mode counter width
  localparam int DSA_NSRC = 7;  // number of activation sources

  // activation source codes
  localparam logic [2:0] DSA_SRC_RX  = 3'h5; // serial_port receive-full
  localparam logic [2:0] DSA_SRC_EXT = 3'h6; // external request pin

  // constant values
  localparam logic [15:0] DSA_PER_HIGH  = 16'hffff;    // forced upper peripheral bits
  localparam logic [23:0] DSA_STEP_BYTE = 24'h000001;  // byte step
  localparam logic [23:0] DSA_STEP_WORD = 24'h000002;  // word step
  localparam logic [15:0] DSA_CNT_ONE   = 16'h0001;    // counter decrement
  localparam logic [7:0]  DSA_RPT_ONE   = 8'h01;       // repeat counter decrement
  localparam logic [7:0]  DSA_RPT_ZERO  = 8'h00;       // repeat reload point
  localparam logic [15:0] DSA_CNT_ZERO  = 16'h0000;    // idle end point

  // reset values
  localparam logic [31:0] DSA_RST_CTRL  = 32'h00000000;
  localparam logic [23:0] DSA_RST_MEM   = 24'h000000;
  localparam logic [7:0]  DSA_RST_PER   = 8'h00;
  localparam logic [15:0] DSA_RST_COUNT = 16'h0000;

  // channel transfer engine
  typedef enum logic [1:0] {
    DSA_ST_IDLE,
    DSA_ST_READ,
    DSA_ST_WRITE
  } dsa_state_t;

endpackage

// >>> hw/dsa_channel.sv
// one short-address dma channel with idle and repeat modes, apb register slave
// assumes on-chip request pulses on mclk, an internal bus that acks each access,
// and an asynchronous active-low external request pin
// the apb side answers with zero wait states; the bus side waits for busAck
// a software write and a transfer end in one cycle: the hardware update wins
//
// Operation
// - idle mode selectable per channel
// - idle: one unit per request, counted
// - receive-full source reads peripheral, else memory
// - memory address holds full 24 bits
// - peripheral address upper 16 bits forced ones
// - idle mode keeps both addresses fixed
// - idle counter 16 bits, decrement per transfer
// - idle zero: clear enable, stop, interrupt
// - idle count zero means 65536 transfers
// - timer, serial and external request sources
// - repeat mode selectable per channel
// - repeat: step memory, peripheral fixed
// - repeat never steps peripheral address
// - repeat live byte reloads from initial
// - reload rewinds memory by count times unit
// - repeat runs until software clears enable
// - re-enable resumes from held state
// - repeat mode never raises interrupt
// - repeat count 8 bits, max 255
`timescale 1ns/1ps

module dsa_channel
  import dsa_pkg::*;
(
  input  wire logic                      mclk,        // system clock
  input  wire logic                      reset,       // synchronous, active high
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // activation sources
  input  wire logic [3:0]                timerMatchA,     // timer_unit channels 0..3
  input  wire logic                      serialTxEmpty,   // serial_port transmit-empty
  input  wire logic                      serialRxFull,    // serial_port receive-full
  input  wire logic                      extReqN,         // external request pin, async
  // internal bus master
  output logic                           busReq,
  output logic                           busWrite,
  output logic                           busWord,
  output logic      [dsa_pkg::DSA_AW-1:0] busAddr,
  output logic      [dsa_pkg::DSA_DW-1:0] busWdata,
  input  wire logic [dsa_pkg::DSA_DW-1:0] busRdata,
  input  wire logic                      busAck,
  // idle-mode end interrupt request
  output logic                           endIrq
);
  import dsa_pkg::*;

  // register state
  logic [31:0]       ctrlFf,  nxt_ctrl;        // control bits
  logic [DSA_AW-1:0] memAddrFf, nxt_memAddr;   // memory_side_address
  logic [7:0]        perLowFf, nxt_perLow;     // peripheral_low_address
  logic [DSA_CW-1:0] countFf, nxt_count;       // transfer_count
  logic              doneFf,  nxt_done;        // idle end flag
  logic              pendFf,  nxt_pend;        // latched request
  // engine state
  dsa_state_t        stFf,    nxt_st;          // transfer phase
  logic [DSA_DW-1:0] dataFf,  nxt_data;        // unit being moved
  logic              rxDirFf, nxt_rxDir;       // direction latched at start
  logic [DSA_AW-1:0] addrFf,  nxt_addr;        // bus address register
  // external pin synchroniser
  logic              extSync1Ff, extSync2Ff, extPrevFf;

  // decoded control fields
  logic              chanEn;                   // channel_enable_bit
  logic              modeRepeat;               // repeat vs idle
  logic              unitWord;                 // unit_size_select
  logic              stepDown;                 // step_direction_select
  logic [2:0]        srcSel;                   // activation source
  logic [DSA_NSRC-1:0] srcEvent;               // all source events
  logic              reqEvent;                 // selected source fired
  logic              extFall;                  // pin falling edge
  logic              swWr;                     // apb write access phase
  logic              xferDone;                 // write phase acked
  logic [DSA_AW-1:0] perAddr;                  // full peripheral address
  logic [DSA_AW-1:0] stepAmt;                  // one unit
  logic [DSA_AW-1:0] rewindAmt;                // initial count times unit
  logic [DSA_AW-1:0] steppedAddr;              // address after one step
  logic [7:0]        liveNext;                 // repeat counter after decrement

  // field decode
  assign chanEn     = ctrlFf[DSA_BIT_EN];
  assign modeRepeat = ctrlFf[DSA_BIT_REPEAT];
  assign unitWord   = ctrlFf[DSA_BIT_SIZE];
  assign stepDown   = ctrlFf[DSA_BIT_DIR];
  assign srcSel     = ctrlFf[DSA_SRC_HI:DSA_SRC_LO];
  assign swWr       = psel & penable & pwrite;
  assign xferDone   = (stFf == DSA_ST_WRITE) & busAck;
  assign extFall    = extPrevFf & ~extSync2Ff;
  assign perAddr    = {DSA_PER_HIGH, perLowFf};

  // source vector, one bit per activation source
  // code 7 selects no source; the range test keeps an out-of-range index
  // from reaching the request latch
  // the external edge arrives two edges after the pin falls
  assign srcEvent = {extFall, serialRxFull, serialTxEmpty, timerMatchA};
  assign reqEvent = srcEvent[srcSel] & (srcSel <= DSA_SRC_EXT);

  // step and rewind amounts
  // the rewind uses the initial count byte, so software must keep it fixed
  // while a repeat cycle runs; a changed byte shifts the rewound address
  // the step direction also picks the sign of the rewind
  assign stepAmt     = unitWord ? DSA_STEP_WORD : DSA_STEP_BYTE;
  assign rewindAmt   = unitWord ? {15'h0000, countFf[7:0], 1'b0}
                                : {16'h0000, countFf[7:0]};
  assign steppedAddr = stepDown ? (memAddrFf - stepAmt) : (memAddrFf + stepAmt);
  assign liveNext    = countFf[15:8] - DSA_RPT_ONE;

  // read data follows paddr at once; it only means something while
  // psel and penable are both high, when the master takes it
  // unmapped offsets read zero and flag an error, writes there do nothing
  // apb: zero wait states, error on unmapped offsets
  always_comb begin
    pready  = 1'b1;
    pslverr = 1'b0;
    prdata  = 32'h00000000;
    case (paddr)
      DSA_OFF_CTRL:   prdata = ctrlFf;
      DSA_OFF_MEM:    prdata = {8'h00, memAddrFf};
      DSA_OFF_PER:    prdata = {24'h000000, perLowFf};
      DSA_OFF_COUNT:  prdata = {16'h0000, countFf};
      DSA_OFF_STATUS: prdata = {30'h00000000, (stFf != DSA_ST_IDLE), doneFf};
      default:        pslverr = psel & penable; // unmapped
    endcase
  end

  // order inside this process matters: the request latch first, then the
  // software write, then the transfer-end update, so that the hardware
  // update has the last word when both fall in one cycle
  // the done flag is set after the clear, so a set wins over a clear
  // register next values: software writes, then hardware updates on top
  always_comb begin
    nxt_ctrl    = ctrlFf;
    nxt_memAddr = memAddrFf;
    nxt_perLow  = perLowFf;
    nxt_count   = countFf;
    nxt_done    = doneFf;
    nxt_pend    = pendFf;
    // request latch, only while enabled
    if (!chanEn) begin
      nxt_pend = 1'b0;
    end else if (reqEvent) begin
      nxt_pend = 1'b1;
    end else if (stFf == DSA_ST_IDLE && pendFf) begin
      nxt_pend = 1'b0; // accepted
    end
    // software writes
    if (swWr) begin
      case (paddr)
        DSA_OFF_CTRL:   nxt_ctrl = pwdata & 32'h0000007f;
        DSA_OFF_MEM:    nxt_memAddr = pwdata[DSA_AW-1:0];
        DSA_OFF_PER:    nxt_perLow = pwdata[7:0];
        DSA_OFF_COUNT:  nxt_count = pwdata[DSA_CW-1:0];
        DSA_OFF_STATUS: begin
          if (pwdata[DSA_BIT_DONE]) begin
            nxt_done = 1'b0; // write one to clear
          end
        end
        default: ;
      endcase
    end
    // end of a transfer; its updates win over a same-cycle write
    if (xferDone) begin
      if (modeRepeat) begin
        // repeat: step memory, peripheral fixed
        nxt_memAddr = steppedAddr;
        if (liveNext == DSA_RPT_ZERO) begin
          nxt_count[15:8] = countFf[7:0];
          nxt_memAddr = stepDown ? (steppedAddr + rewindAmt)
                                 : (steppedAddr - rewindAmt);
        end else begin
          nxt_count[15:8] = liveNext;
        end
      end else begin
        // idle: addresses untouched, wrap from zero gives 65536
        nxt_memAddr = memAddrFf;
        nxt_count   = countFf - DSA_CNT_ONE;
        if (countFf == DSA_CNT_ONE) begin
          nxt_ctrl[DSA_BIT_EN] = 1'b0;
          nxt_done = 1'b1;
        end
      end
    end
  end

  // register file storage
  // the synchroniser sits here too; only the second stage feeds logic,
  // and the edge register starts at the idle level of the pin
  // so no false request follows reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrlFf     <= DSA_RST_CTRL;
      memAddrFf  <= DSA_RST_MEM;
      perLowFf   <= DSA_RST_PER;
      countFf    <= DSA_RST_COUNT;
      doneFf     <= 1'b0;
      pendFf     <= 1'b0;
      extSync1Ff <= 1'b1;
      extSync2Ff <= 1'b1;
      extPrevFf  <= 1'b1;
    end else begin
      ctrlFf     <= nxt_ctrl;
      memAddrFf  <= nxt_memAddr;
      perLowFf   <= nxt_perLow;
      countFf    <= nxt_count;
      doneFf     <= nxt_done;
      pendFf     <= nxt_pend;
      extSync1Ff <= extReqN;    // first stage, read only by second
      extSync2Ff <= extSync1Ff;
      extPrevFf  <= extSync2Ff;
    end
  end

  // the engine takes one pending request at a time and runs a read phase
  // and then a write phase, each held until its busAck
  // the direction is latched at the start, so a source change during a
  // transfer cannot swap the two addresses halfway
  // transfer engine next state
  always_comb begin
    nxt_st    = stFf;
    nxt_data  = dataFf;
    nxt_rxDir = rxDirFf;
    nxt_addr  = addrFf;
    case (stFf)
      DSA_ST_IDLE: begin
        // start only when enabled and a request is pending
        if (chanEn && pendFf) begin
          nxt_st    = DSA_ST_READ;
          nxt_rxDir = (srcSel == DSA_SRC_RX);
          nxt_addr  = (srcSel == DSA_SRC_RX) ? perAddr : memAddrFf;
        end
      end
      DSA_ST_READ: begin
        // capture the unit, then address the destination
        if (busAck) begin
          nxt_st   = DSA_ST_WRITE;
          nxt_data = unitWord ? busRdata : {8'h00, busRdata[7:0]};
          nxt_addr = rxDirFf ? memAddrFf : perAddr;
        end
      end
      DSA_ST_WRITE: begin
        // one unit per request
        if (busAck) begin
          nxt_st = DSA_ST_IDLE;
        end
      end
      default: nxt_st = DSA_ST_IDLE;
    endcase
  end

  // transfer engine storage
  always_ff @(posedge mclk) begin
    if (reset) begin
      stFf    <= DSA_ST_IDLE;
      dataFf  <= '0;
      rxDirFf <= 1'b0;
      addrFf  <= '0;
    end else begin
      stFf    <= nxt_st;
      dataFf  <= nxt_data;
      rxDirFf <= nxt_rxDir;
      addrFf  <= nxt_addr;
    end
  end

  // busReq drops for at least one cycle between two transfers
  // the unit size follows the control register; software must not change
  // it while a transfer is in flight
  // bus outputs, address and data from flip-flops
  assign busReq   = (stFf != DSA_ST_IDLE);
  assign busWrite = (stFf == DSA_ST_WRITE);
  assign busWord  = unitWord;
  assign busAddr  = addrFf;
  assign busWdata = dataFf;
  // idle end only; repeat mode never sets the flag
  assign endIrq   = doneFf;

  // assertions
  // all on mclk, all off during reset
  // antecedents of the register update and hold checks, except repeat_no_irq_a, pend_clear_a, disabled_hold_a and bus_hold_a, leave out
  // cycles with a software write, since a write may legally change the registers that a check looks at
  default clocking dsa_cb @(posedge mclk); endclocking
  default disable iff (reset);

  idle_addr_fixed_a: assert property (xferDone && !modeRepeat && !swWr |=> $stable(memAddrFf))
    else $error("idle mode memory address moved");
  per_high_ones_a: assert property (busReq && ((busWrite && !rxDirFf) || (!busWrite && rxDirFf))
                                    |-> busAddr[23:8] == DSA_PER_HIGH)
    else $error("peripheral address upper bits not all ones");
  rx_dir_read_a: assert property ($rose(busReq) && rxDirFf |-> busAddr == perAddr)
    else $error("receive-full transfer did not read peripheral");
  idle_count_dec_a: assert property (xferDone && !modeRepeat && !swWr
                                     |=> countFf == $past(countFf) - DSA_CNT_ONE)
    else $error("idle counter did not step by one");
  idle_end_a: assert property (xferDone && !modeRepeat && !swWr && countFf == DSA_CNT_ONE
                               |=> !chanEn && doneFf && endIrq ##1 stFf == DSA_ST_IDLE)
    else $error("idle end did not stop and interrupt");
  repeat_no_irq_a: assert property (xferDone && modeRepeat && !doneFf |=> !endIrq)
    else $error("repeat mode raised interrupt");
  repeat_reload_a: assert property (xferDone && modeRepeat && !swWr && countFf[15:8] == DSA_RPT_ONE
                                    |=> countFf[15:8] == $past(countFf[7:0]))
    else $error("repeat counter not reloaded");
  repeat_keep_en_a: assert property (xferDone && modeRepeat && chanEn && !swWr |=> chanEn)
    else $error("hardware cleared enable in repeat mode");
  disabled_hold_a: assert property (!chanEn && stFf == DSA_ST_IDLE |=> stFf == DSA_ST_IDLE)
    else $error("disabled channel started a transfer");

  // peripheral low byte never moves with a transfer
  per_low_fixed_a: assert property (xferDone && !swWr
                                    |=> $stable(perLowFf))
    else $error("peripheral address stepped");

  // repeat mode steps memory by one unit when no reload is due
  repeat_step_a: assert property (xferDone && modeRepeat && !swWr && countFf[15:8] != DSA_RPT_ONE
                                  |=> memAddrFf == ($past(stepDown) ? $past(memAddrFf) - $past(stepAmt)
                                                                    : $past(memAddrFf) + $past(stepAmt)))
    else $error("repeat memory address did not step by one unit");

  // repeat live byte counts down by one when no reload is due
  repeat_live_dec_a: assert property (xferDone && modeRepeat && !swWr && countFf[15:8] != DSA_RPT_ONE
                                      |=> countFf[15:8] == $past(countFf[15:8]) - DSA_RPT_ONE)
    else $error("repeat live count did not step by one");

  // in repeat mode the initial count byte is never touched by hardware
  repeat_init_hold_a: assert property (xferDone && modeRepeat && !swWr
                                       |=> countFf[7:0] == $past(countFf[7:0]))
    else $error("repeat initial count changed");

  // disabled and idle: addresses and counters hold
  disabled_state_a: assert property (!chanEn && stFf == DSA_ST_IDLE && !swWr
                                      |=> $stable(memAddrFf) && $stable(countFf))
    else $error("disabled channel changed its state");

  // a disabled channel drops any pending request
  pend_clear_a: assert property (!chanEn
                                 |=> !pendFf)
    else $error("disabled channel kept a pending request");

  // one unit per request: the bus is released after the write phase
  one_unit_a: assert property (xferDone
                               |=> !busReq)
    else $error("transfer ran past one unit");

  // each phase holds address and direction until its ack
  bus_hold_a: assert property (busReq && !busAck
                               |=> busReq && $stable(busAddr) && $stable(busWrite))
    else $error("bus phase changed before ack");

  // receive-full source writes to the memory address
  rx_dir_write_a: assert property ($rose(busWrite) && rxDirFf
                                   |-> busAddr == $past(memAddrFf))
    else $error("receive-full transfer did not write memory");

  // idle mode runs on while the counter has not reached its end
  idle_run_on_a: assert property (xferDone && !modeRepeat && !swWr && chanEn && countFf != DSA_CNT_ONE
                                  |=> chanEn)
    else $error("idle mode stopped before its count");

  idle_end_c: cover property (xferDone && !modeRepeat && countFf == DSA_CNT_ONE);
  repeat_reload_c: cover property (xferDone && modeRepeat && countFf[15:8] == DSA_RPT_ONE);
  rx_xfer_c: cover property (xferDone && rxDirFf);
  ext_start_c: cover property (extFall && srcSel == DSA_SRC_EXT ##[1:4] $rose(busReq));
  repeat_resume_c: cover property ($rose(chanEn) && modeRepeat);

endmodule // dsa_channel

// >>> test/dsa_bus_model.sv
// internal bus slave model: acks each phase after a set wait, data from address
// assumes the channel holds busReq, busWrite and busAddr until busAck
`timescale 1ns/1ps
module dsa_bus_model (
  input  wire logic        mclk,     // system clock
  input  wire logic [3:0]  ackWait,  // idle cycles before each ack
  input  wire logic        busReq,
  input  wire logic        busWrite,
  input  wire logic [23:0] busAddr,
  input  wire logic [15:0] busWdata,
  output logic      [15:0] busRdata,
  output logic             busAck,
  output logic      [23:0] wrAddr,   // last written address
  output logic      [15:0] wrData,   // last written data
  output int               wrCount   // writes seen
);
  logic [3:0]  waitCnt = 4'h0; // cycles waited in this phase
  logic [15:0] pat;            // data for the current address
  initial busAck = 1'b0;
  initial wrCount = 0;
  assign pat = busAddr[15:0] ^ 16'h5a5a;
  // off the ack cycle the lines show the inverse, never a stale match
  assign busRdata = busAck ? pat : ~pat;
  // ack one phase at a time, log every write
  always @(posedge mclk) begin
    busAck <= 1'b0;
    if (busReq && !busAck) begin
      if (waitCnt >= ackWait) begin
        busAck <= 1'b1;
        waitCnt <= 4'h0;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
    if (busAck && busWrite) begin
      wrAddr <= busAddr;
      wrData <= busWdata;
      wrCount <= wrCount + 1;
    end
  end
endmodule // dsa_bus_model

// >>> test/tb_top.sv
// testbench for the short-address dma channel: apb tasks, request pulses
// assumes dsa_channel and the bus model above; mclk 100 MHz
`timescale 1ns/1ps
module tb_top;
  import dsa_pkg::*;
  logic        mclk = 1'b0, reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdVal;
  logic        pready, pslverr, rdErr;
  logic [3:0]  timerMatchA = 4'h0, ackWait = 4'h0;
  logic        serialTxEmpty = 1'b0, serialRxFull = 1'b0, extReqN = 1'b1;
  logic        busReq, busWrite, busWord, busAck, endIrq;
  logic [23:0] busAddr, wrAddr, m, p;
  logic [15:0] busWdata, busRdata, wrData;
  int          wrCount, errors = 0, checkCount = 0, n;
  logic [31:0] capData = 32'h0;     // read data taken at the access edge
  logic        capErr = 1'b0, wordSeen = 1'b0;

  dsa_channel dsa_channel_i (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timerMatchA, .serialTxEmpty, .serialRxFull, .extReqN,
    .busReq, .busWrite, .busWord, .busAddr, .busWdata, .busRdata, .busAck, .endIrq);
  dsa_bus_model dsa_bus_model_i (.mclk, .ackWait, .busReq, .busWrite, .busAddr,
    .busWdata, .busRdata, .busAck, .wrAddr, .wrData, .wrCount);

  always #5 mclk = ~mclk;

  // take apb answer at the edge that completes the access
  always @(posedge mclk) begin
    if (psel && penable && pready) begin
      capData <= prdata;
      capErr <= pslverr;
    end
    if (busAck && busWrite) wordSeen <= busWord;
  end

  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, then one idle cycle so psel never toggles in one step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    rdVal = capData;
    rdErr = capErr;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdVal, exp);
  endtask
  // one-cycle event on the chosen source
  task fire(input int s);
    case (s)
      0, 1, 2, 3: timerMatchA[s] <= 1'b1;
      4: serialTxEmpty <= 1'b1;
      5: serialRxFull <= 1'b1;
      default: extReqN <= 1'b0;
    endcase
    @(posedge mclk);
    timerMatchA <= 4'h0;
    serialTxEmpty <= 1'b0;
    serialRxFull <= 1'b0;
    extReqN <= 1'b1;
    @(posedge mclk);
  endtask
  // fire, wait for the write phase, compare where and what was written
  task xfer(input int s, input logic [23:0] ea, input logic [15:0] ed);
    int t;
    n = wrCount;
    fire(s);
    t = 0;
    while (wrCount == n && t < 100) begin
      @(posedge mclk);
      t++;
    end
    chk({8'h00, wrAddr}, {8'h00, ea});
    chk({16'h0, wrData}, {16'h0, ed});
    repeat (3) @(posedge mclk);
  endtask
  function logic [15:0] pat(input logic [23:0] a);
    pat = a[15:0] ^ 16'h5a5a;
  endfunction
  function logic [15:0] byt(input logic [23:0] a);
    byt = {8'h00, a[7:0] ^ 8'h5a};
  endfunction
  // control word: f = {down, word, repeat, enable}
  function logic [31:0] cw(input int s, input logic [3:0] f);
    cw = {25'h0, s[2:0], f};
  endfunction

  task finish_test;
    $display("checks=%0d errors=%0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    errors++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(DSA_OFF_CTRL, 32'h0);
    rd(DSA_OFF_COUNT, 32'h0);
    rd(DSA_OFF_STATUS, 32'h0);
    rd(8'h14, 32'h0);
    chk({31'h0, rdErr}, 32'h1);
    $display("test reset done");
    // every source, idle byte mode, one transfer each
    for (int s = 0; s < 7; s++) begin
      ackWait <= 4'(s);
      m = 24'hab2340 + 24'(s);
      p = {16'hffff, 8'h30 + 8'(s)};
      wr(DSA_OFF_MEM, {8'h00, m});
      wr(DSA_OFF_PER, {24'h0, p[7:0]});
      wr(DSA_OFF_COUNT, 32'h1);
      wr(DSA_OFF_CTRL, cw(s, 4'h1));
      if (s == 5) xfer(s, m, byt(p));
      else xfer(s, p, byt(m));
      chk({31'h0, wordSeen}, 32'h0);
      rd(DSA_OFF_CTRL, cw(s, 4'h0));
      chk({31'h0, endIrq}, 32'h1);
      rd(DSA_OFF_MEM, {8'h00, m});
      wr(DSA_OFF_STATUS, 32'h1);
      chk({31'h0, endIrq}, 32'h0);
    end
    $display("test sources done");
    // idle word mode, down set, three transfers, slow bus
    ackWait <= 4'h3;
    m = 24'h45678a;
    p = 24'hffff44;
    wr(DSA_OFF_MEM, {8'h00, m});
    wr(DSA_OFF_PER, 32'h44);
    wr(DSA_OFF_COUNT, 32'h3);
    wr(DSA_OFF_CTRL, cw(2, 4'hd));
    for (int i = 0; i < 3; i++) begin
      xfer(2, p, pat(m));
      chk({31'h0, wordSeen}, 32'h1);
      rd(DSA_OFF_COUNT, 32'(2 - i));
      chk({31'h0, endIrq}, 32'(i == 2));
    end
    rd(DSA_OFF_MEM, {8'h00, m});
    wr(DSA_OFF_STATUS, 32'h1);
    // zero count runs on past zero
    wr(DSA_OFF_COUNT, 32'h0);
    wr(DSA_OFF_CTRL, cw(0, 4'h1));
    xfer(0, p, byt(m));
    rd(DSA_OFF_COUNT, 32'hffff);
    rd(DSA_OFF_CTRL, cw(0, 4'h1));
    wr(DSA_OFF_CTRL, 32'h0);
    $display("test idle count done");
    // repeat word up, count 2, pause and resume, then reload
    ackWait <= 4'h1;
    wr(DSA_OFF_MEM, 32'h100);
    wr(DSA_OFF_COUNT, 32'h0202);
    wr(DSA_OFF_CTRL, cw(1, 4'h7));
    xfer(1, p, pat(24'h100));
    rd(DSA_OFF_MEM, 32'h102);
    rd(DSA_OFF_COUNT, 32'h0102);
    wr(DSA_OFF_CTRL, cw(1, 4'h6));
    n = wrCount;
    fire(1);
    repeat (20) @(posedge mclk);
    chk(32'(wrCount), 32'(n));
    rd(DSA_OFF_MEM, 32'h102);
    wr(DSA_OFF_CTRL, cw(1, 4'h7));
    xfer(1, p, pat(24'h102));
    rd(DSA_OFF_MEM, 32'h100);
    rd(DSA_OFF_COUNT, 32'h0202);
    rd(DSA_OFF_CTRL, cw(1, 4'h7));
    chk({31'h0, endIrq}, 32'h0);
    rd(DSA_OFF_PER, 32'h44);
    // repeat byte down, receive source, count 1 rewinds upward
    wr(DSA_OFF_MEM, 32'h200);
    wr(DSA_OFF_COUNT, 32'h0101);
    wr(DSA_OFF_CTRL, cw(5, 4'hb));
    xfer(5, 24'h000200, byt(p));
    rd(DSA_OFF_MEM, 32'h200);
    rd(DSA_OFF_COUNT, 32'h0101);
    // full 8-bit count, external source
    wr(DSA_OFF_COUNT, 32'hffff);
    wr(DSA_OFF_CTRL, cw(6, 4'h3));
    xfer(6, p, byt(24'h000200));
    rd(DSA_OFF_MEM, 32'h201);
    rd(DSA_OFF_COUNT, 32'hfeff);
    rd(DSA_OFF_STATUS, 32'h0);
    $display("test repeat done");
    finish_test();
  end
endmodule // tb_top
